/* pan_pkg.sv */
package pan_pkg;

  // Register indices of the management map (one 32-bit word each).
  localparam logic [7:0]  REG_CONTROL   = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h01;
  localparam logic [7:0]  REG_ADVERT    = 8'h04;
  localparam logic [7:0]  REG_PARTNER   = 8'h05;
  localparam logic [7:0]  REG_IRQ_CTRL  = 8'h10;
  localparam logic [7:0]  REG_EVT_STAT  = 8'h11;
  localparam logic [7:0]  REG_EVT_MASK  = 8'h12;

  // Control register fields.
  localparam int CTL_PCS_RESET   = 15;
  localparam int CTL_AN_ENABLE   = 12;
  localparam int CTL_AN_RESTART  = 9;
  localparam int CTL_SGMII_MODE  = 0;
  localparam int CTL_MGMT_ENABLE = 1;
  localparam logic [15:0] CONTROL_RESET = 16'h1002;

  // Status register fields.
  localparam int STS_AN_COMPLETE = 5;
  localparam int STS_AN_ABILITY  = 3;

  // Advertisement layout, shared with the partner ability register.
  localparam logic [15:0] ADVERT_WMASK  = 16'hB1A0;
  localparam logic [15:0] ADVERT_RESET  = 16'h01A0;
  localparam logic [15:0] SGMII_MASK    = 16'hFFFF;
  localparam int ADV_FAULT_LO = 12;

  // Interrupt control fields.
  localparam int IRQ_STATUS = 1;
  localparam int IRQ_ENABLE = 0;

  // Event bits of the sticky status register.
  localparam int EVT_COMPLETE = 0;
  localparam int EVT_SYNC_LOST = 1;
  localparam int EVT_PAGE_RX  = 2;
  localparam int EVT_WIDTH    = 3;

  // Link timer figures.
  localparam real CLK_MHZ          = 200.0;
  localparam real TIMER_X_MIN_MS   = 10.354;
  localparam real TIMER_SG_MIN_MS  = 1.606;
  localparam int  TIMER_X_CYCLES   =
    int'($ceil(TIMER_X_MIN_MS * CLK_MHZ * 1000.0));
  localparam int  TIMER_SG_CYCLES  =
    int'($ceil(TIMER_SG_MIN_MS * CLK_MHZ * 1000.0));

  typedef enum logic [3:0] {
    AN_IDLE     = 4'b0001,
    AN_ADVERT   = 4'b0010,
    AN_ACK      = 4'b0100,
    AN_COMPLETE = 4'b1000
  } pan_state_type;

  typedef struct packed {
    logic        valid;
    logic        ack;
    logic [15:0] word;
  } pan_page_type;

endpackage : pan_pkg

/* pan_autoneg.sv */
// Operation
// RULE_01: Negotiate only when negotiation enable and management enable are set.
// RULE_02: Start negotiation after power-up, reset and management enabling.
// RULE_03: Restart negotiation when receive synchronization is lost.
// RULE_04: Enter negotiation when the partner begins an exchange.
// RULE_05: Restart on software restart request or sublayer reset bit.
// RULE_06: Transmit the advertisement register contents to the partner.
// RULE_07: Capture partner abilities in the advertisement field layout.
// RULE_08: Set the completion status bit when a cycle completes.
// RULE_09: Non-SGMII link timer lasts 10.354 ms to 10.387 ms.
// RULE_10: SGMII link timer lasts 1.606 ms to 1.638 ms.
// RULE_11: In SGMII mode exchange speed as well as duplex.
// RULE_12: The SGMII PHY passes its medium results through this exchange.
// RULE_13: Disabled interrupt keeps the interrupt output low.
// RULE_14: Enabled interrupt drives the output high on completion.
// RULE_15: Interrupt stays high until software writes zero to its status.
// RULE_16: Negotiation exists only with the management interface present.
// RULE_17: Disabled interrupt forces the interrupt status bit to zero.
// RULE_18: Completion bit reads one once complete, zero otherwise.
// RULE_19: Timer length follows the mode: SGMII or the other duration.
`timescale 1ns/100ps
module pan_autoneg
  import pan_pkg::*;
#(
  parameter int TIMER_X_LEN  = TIMER_X_CYCLES,
  parameter int TIMER_SG_LEN = TIMER_SG_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // Register port.
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [31:0] reg_rdata_out,
  // Link side.
  input  wire logic        rx_sync_in,
  input  wire pan_page_type rx_page_in,
  output pan_page_type     tx_page_out,
  // Status and interrupts.
  output logic             an_complete_out,
  output logic             negotiation_irq_out,
  output logic             event_irq_out
);

  logic [15:0]   control;
  logic [15:0]   advert;
  logic [15:0]   partner;
  logic          irq_enable;
  logic          irq_status;
  logic [EVT_WIDTH-1:0] evt_stat;
  logic [EVT_WIDTH-1:0] evt_mask;
  logic          an_complete;
  logic          sync_prev;
  logic          mgmt_prev;
  logic          partner_prev;
  logic          restart_req;
  logic          boot_pending;
  pan_state_type state;
  logic [31:0]   timer;
  logic          page_rx;
  logic          done_pulse;
  logic          start_cond;
  logic          an_active;
  logic [31:0]   timer_len;

  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = reg_write_in && (reg_addr_in == idx);
  endfunction : wr_hit

  assign an_active  = control[CTL_AN_ENABLE]
                      && control[CTL_MGMT_ENABLE]; // RULE_01 RULE_16
  assign timer_len  = control[CTL_SGMII_MODE] ? 32'(TIMER_SG_LEN)
                      : 32'(TIMER_X_LEN); // RULE_19 RULE_09 RULE_10
  assign start_cond = boot_pending // RULE_02
                      || (control[CTL_MGMT_ENABLE] && !mgmt_prev) // RULE_02
                      || (sync_prev && !rx_sync_in) // RULE_03
                      || (rx_page_in.valid && !rx_page_in.ack
                          && !partner_prev) // RULE_04
                      || restart_req; // RULE_05
  assign page_rx    = rx_page_in.valid && state != AN_IDLE;
  assign done_pulse = (state == AN_ACK) && (timer == 32'h0)
                      && rx_page_in.valid && rx_page_in.ack;

  // Software-writable control; restart and reset bits self-clear.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      control     <= CONTROL_RESET;
      restart_req <= 1'b0;
    end else begin
      restart_req <= 1'b0;
      if (wr_hit(REG_CONTROL)) begin
        control <= reg_wdata_in[15:0] & ~16'h8200;
        restart_req <= reg_wdata_in[CTL_AN_RESTART]
                       || reg_wdata_in[CTL_PCS_RESET]; // RULE_05
      end
    end
  end

  // Edge history for start conditions.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_prev    <= 1'b0;
      mgmt_prev    <= 1'b0;
      partner_prev <= 1'b0;
      boot_pending <= 1'b1;
    end else begin
      sync_prev    <= rx_sync_in;
      mgmt_prev    <= control[CTL_MGMT_ENABLE];
      partner_prev <= rx_page_in.valid;
      if (an_active) begin
        boot_pending <= 1'b0;
      end
    end
  end

  // Advertisement; the fault field clears once negotiation completes.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      advert <= ADVERT_RESET;
    end else if (wr_hit(REG_ADVERT)) begin
      advert <= reg_wdata_in[15:0] & ADVERT_WMASK;
    end else if (done_pulse) begin
      advert[ADV_FAULT_LO+1:ADV_FAULT_LO] <= 2'h0;
    end
  end

  // Negotiation sequencer paced by the link timer.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state       <= AN_IDLE;
      timer       <= 32'h0;
      an_complete <= 1'b0;
    end else if (!an_active) begin
      state       <= AN_IDLE;
      timer       <= 32'h0;
      an_complete <= 1'b0;
    end else if (start_cond) begin
      state       <= AN_ADVERT;
      timer       <= timer_len - 32'h1;
      an_complete <= 1'b0;
    end else begin
      if (timer != 32'h0) begin
        timer <= timer - 32'h1;
      end
      case (state)
        AN_IDLE: begin
          state <= AN_IDLE;
        end
        AN_ADVERT: begin
          if (timer == 32'h0 && page_rx) begin
            state <= AN_ACK;
            timer <= timer_len - 32'h1;
          end
        end
        AN_ACK: begin
          if (done_pulse) begin
            state       <= AN_COMPLETE;
            an_complete <= 1'b1; // RULE_08 RULE_18
          end
        end
        AN_COMPLETE: begin
          state <= AN_COMPLETE;
        end
        default: begin
          state <= AN_IDLE;
        end
      endcase
    end
  end

  // Partner abilities; SGMII pages carry speed and duplex bits too.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      partner <= 16'h0000;
    end else if (page_rx) begin
      partner <= rx_page_in.word & (control[CTL_SGMII_MODE] ? SGMII_MASK
                 : (ADVERT_WMASK | 16'h4040)); // RULE_07 RULE_11 RULE_12
    end
  end

  // Transmitted page mirrors the advertisement register.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_page_out <= '0;
    end else begin
      tx_page_out.valid <= an_active && state != AN_IDLE;
      tx_page_out.ack   <= state == AN_ACK || state == AN_COMPLETE;
      tx_page_out.word  <= advert; // RULE_06
    end
  end

  // Negotiation interrupt control; a completion wins over a clear.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_enable <= 1'b1;
      irq_status <= 1'b0;
    end else begin
      if (wr_hit(REG_IRQ_CTRL)) begin
        irq_enable <= reg_wdata_in[IRQ_ENABLE];
      end
      if (!irq_enable) begin
        irq_status <= 1'b0; // RULE_17 RULE_13
      end else if (done_pulse) begin
        irq_status <= 1'b1; // RULE_14
      end else if (wr_hit(REG_IRQ_CTRL) && !reg_wdata_in[IRQ_STATUS]) begin
        irq_status <= 1'b0; // RULE_15
      end
    end
  end

  // Sticky event bits, write one to clear; a new event wins.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      evt_stat <= '0;
      evt_mask <= '0;
    end else begin
      if (wr_hit(REG_EVT_MASK)) begin
        evt_mask <= reg_wdata_in[EVT_WIDTH-1:0];
      end
      evt_stat <= (evt_stat & ~(wr_hit(REG_EVT_STAT)
                   ? reg_wdata_in[EVT_WIDTH-1:0] : '0))
                  | {page_rx, sync_prev && !rx_sync_in, done_pulse};
    end
  end

  // Registered outputs.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      an_complete_out     <= 1'b0;
      negotiation_irq_out <= 1'b0;
      event_irq_out       <= 1'b0;
    end else begin
      an_complete_out     <= an_complete;
      negotiation_irq_out <= irq_status && irq_enable; // RULE_13 RULE_15
      event_irq_out       <= |(evt_stat & evt_mask);
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h0;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        REG_CONTROL:  reg_rdata_out <= {16'h0, control};
        REG_STATUS:   reg_rdata_out <= {26'h0, an_complete, 1'b0, 1'b1,
                                        rx_sync_in && an_complete,
                                        2'h0}; // RULE_18
        REG_ADVERT:   reg_rdata_out <= {16'h0, advert};
        REG_PARTNER:  reg_rdata_out <= {16'h0, partner};
        REG_IRQ_CTRL: reg_rdata_out <= {30'h0, irq_status, irq_enable};
        REG_EVT_STAT: reg_rdata_out <= {29'h0, evt_stat};
        REG_EVT_MASK: reg_rdata_out <= {29'h0, evt_mask};
        default:      reg_rdata_out <= 32'h0;
      endcase
    end else begin
      reg_rdata_out <= 32'h0;
    end
  end

endmodule : pan_autoneg

/* pan_checker.sv */
`timescale 1ns/100ps
module pan_checker
  import pan_pkg::*;
(
  // Clock, reset and register port.
  input wire logic         clk_sys_in,
  input wire logic         rst_n_in,
  input wire logic [7:0]   reg_addr_in,
  input wire logic [31:0]  reg_wdata_in,
  input wire logic         reg_write_in,
  input wire logic         reg_read_in,
  input wire logic [31:0]  reg_rdata_out,
  // Link and status.
  input wire logic         rx_sync_in,
  input wire pan_page_type rx_page_in,
  input wire pan_page_type tx_page_out,
  input wire logic         an_complete_out,
  input wire logic         negotiation_irq_out,
  input wire logic         event_irq_out
);
  logic en_q;
  logic an_q;
  // Shadows of the interrupt enable and negotiation enable bits.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_q <= 1'b1;
      an_q <= 1'b1;
    end else if (reg_write_in) begin
      if (reg_addr_in == REG_IRQ_CTRL) en_q <= reg_wdata_in[IRQ_ENABLE];
      if (reg_addr_in == REG_CONTROL) an_q <= reg_wdata_in[CTL_AN_ENABLE];
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  irq_low_a: assert property (!en_q ##1 !en_q |-> !negotiation_irq_out)
    else $error("irq high while disabled");
  irq_hold_a: assert property (negotiation_irq_out && en_q &&
    !(reg_write_in && reg_addr_in == REG_IRQ_CTRL) &&
    !$past(reg_write_in && reg_addr_in == REG_IRQ_CTRL)
    |=> negotiation_irq_out)
    else $error("irq dropped without clear");
  irq_set_a: assert property ($rose(an_complete_out) && en_q |->
    negotiation_irq_out) else $error("irq missing at completion");
  rdata_idle_a: assert property (!reg_read_in |=> reg_rdata_out == '0)
    else $error("read data outside read slot");
  tx_off_a: assert property (!an_q ##1 !an_q |-> !tx_page_out.valid)
    else $error("pages sent while disabled");
  done_page_a: assert property ($rose(an_complete_out) |->
    $past(rx_page_in.ack, 2)) else $error("completion without ack");
  sync_loss_a: assert property ($fell(rx_sync_in) |->
    ##[1:3] !an_complete_out) else $error("no restart on sync loss");
  status_rd_a: assert property (reg_read_in &&
    reg_addr_in == REG_STATUS |=> reg_rdata_out[STS_AN_ABILITY] &&
    reg_rdata_out[STS_AN_COMPLETE] == $past(an_complete_out))
    else $error("status bits wrong");
  cover property ($rose(an_complete_out));
  cover property ($rose(negotiation_irq_out));
  cover property ($fell(rx_sync_in));
endmodule : pan_checker
bind pan_autoneg pan_checker chk_u (.clk_sys_in, .rst_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .rx_sync_in,
  .rx_page_in, .tx_page_out, .an_complete_out, .negotiation_irq_out,
  .event_irq_out);

/* pan_partner.sv */
`timescale 1ns/100ps
module pan_partner
  import pan_pkg::*;
(
  // Clock and control.
  input wire logic         clk_sys_in,
  input wire logic         rst_n_in,
  input wire logic         en_in,
  input wire logic [15:0]  word_in,
  // Link.
  input wire pan_page_type tx_page_in,
  output pan_page_type     page_out
);
  // Acknowledges only once the device's page is seen; an idle word churns.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_out <= '0;
    end else begin
      page_out.valid <= en_in;
      // The first valid page goes out without ack, so the device sees a
      // fresh exchange begin before it is acknowledged.
      page_out.ack   <= en_in && page_out.valid && tx_page_in.valid;
      page_out.word  <= en_in ? word_in : ~page_out.word;
    end
  end
endmodule : pan_partner

/* tb_pan_autoneg.sv */
`timescale 1ns/100ps
module tb_pan_autoneg;
  import pan_pkg::*;
  localparam int XL = 40;
  localparam int SL = 20;
  logic clk_sys_in = 0, rst_n_in = 0, reg_write_in = 0, reg_read_in = 0;
  logic rx_sync_in = 1, p_en = 1, an_complete_out, negotiation_irq_out;
  logic event_irq_out;
  logic [7:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out;
  logic [15:0] p_word = 16'h0180;
  pan_page_type rx_page_in, tx_page_out;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, t, k;
  pan_autoneg #(.TIMER_X_LEN(XL), .TIMER_SG_LEN(SL)) dut_u (.clk_sys_in,
    .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
    .reg_rdata_out, .rx_sync_in, .rx_page_in, .tx_page_out,
    .an_complete_out, .negotiation_irq_out, .event_irq_out);
  pan_partner peer_u (.clk_sys_in, .rst_n_in, .en_in(p_en), .word_in(p_word),
    .tx_page_in(tx_page_out), .page_out(rx_page_in));
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_write_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_read_in <= 1'b0;
    #1 chk(reg_rdata_out & m, e);
  endtask : rd
  // Counts cycles until a fresh completion, past any stale one.
  task automatic done(input int len);
    t = 0;
    while (an_complete_out === 1'b1 && t < 9) begin
      @(posedge clk_sys_in);
      t++;
    end
    while (an_complete_out !== 1'b1 && t < 400) begin
      @(posedge clk_sys_in);
      t++;
    end
    #1 chk(an_complete_out, 1);
    if (len > 0) chk(t >= 2 * len - 4 && t <= 2 * len + 8, 1);
  endtask : done
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc > 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(REG_CONTROL, 32'h1002, '1);
    rd(REG_IRQ_CTRL, 32'h1, '1);
    rd(REG_ADVERT, 32'h01A0, '1);
    rd(REG_STATUS, 32'h8, 32'h28);
    rd(8'h20, 32'h0, '1);
    done(0);
    rd(REG_STATUS, 32'h28, 32'h28);
    rd(REG_PARTNER, 32'h0180, 32'hB1A0);
    chk(negotiation_irq_out, 1);
    repeat (10) @(posedge clk_sys_in);
    chk(negotiation_irq_out, 1);
    wr(REG_IRQ_CTRL, 32'h1);
    rd(REG_IRQ_CTRL, 32'h1, '1);
    chk(negotiation_irq_out, 0);
    $display("test boot done");
    wr(REG_EVT_MASK, 32'h0);
    rd(REG_EVT_STAT, 32'h1, 32'h1);
    chk(event_irq_out, 0);
    wr(REG_EVT_MASK, 32'h1);
    rd(REG_EVT_MASK, 32'h1, '1);
    chk(event_irq_out, 1);
    wr(REG_EVT_STAT, 32'h7);
    rd(REG_EVT_STAT, 32'h0, 32'h1);
    chk(event_irq_out, 0);
    $display("test events done");
    wr(REG_ADVERT, 32'hFFFF);
    rd(REG_ADVERT, 32'hB1A0, '1);
    wr(REG_CONTROL, 32'h1202);
    repeat (3) @(posedge clk_sys_in);
    chk(tx_page_out.word, 32'hB1A0);
    done(XL);
    wr(REG_IRQ_CTRL, 32'h0);
    wr(REG_CONTROL, 32'h9002);
    done(0);
    chk(negotiation_irq_out, 0);
    rd(REG_IRQ_CTRL, 32'h0, '1);
    wr(REG_IRQ_CTRL, 32'h1);
    $display("test restart done");
    @(posedge clk_sys_in);
    rx_sync_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chk(an_complete_out, 0);
    rx_sync_in <= 1'b1;
    done(0);
    p_en <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    p_en <= 1'b1;
    done(XL);
    p_word <= 16'hD801;
    wr(REG_CONTROL, 32'h1203);
    done(SL);
    rd(REG_PARTNER, 32'hD801, '1);
    $display("test link done");
    for (int i = 0; i < 2; i++) begin
      wr(REG_CONTROL, i ? 32'h1200 : 32'h0202);
      k = 0;
      repeat (2) @(posedge clk_sys_in);
      repeat (100) begin
        @(posedge clk_sys_in);
        k += tx_page_out.valid;
      end
      chk(k, 0);
    end
    $display("test disable done");
    conclude();
  end
endmodule : tb_pan_autoneg
